// ---- clock_ctrl_parts.sv ----
`timescale 1ns/1ns

package clock_ctrl_pkg;
  // ---------------------------------------------------------------
  // register map, word offsets on the avalon byte address
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_MAIN_MODE  = 5'h00;
  localparam logic [4:0] ADDR_PROC_CLOCK = 5'h04;
  localparam logic [4:0] ADDR_OSC_CTRL   = 5'h08;
  localparam logic [4:0] ADDR_STAB_SEL   = 5'h0C;
  localparam logic [4:0] ADDR_STAB_STAT  = 5'h10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SEL_BIT    = 0;
  localparam int STATUS_BIT = 1;
  localparam int SUB_SEL_BIT   = 4;
  localparam int HALT_BIT      = 7;
  localparam int MAIN_STOP_BIT = 0;
  localparam int NUM_FLAGS  = 5;
  localparam int SEL_W      = 3;
  localparam int CNT_W      = 20;

  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic             RST_SEL     = 1'b0;
  localparam logic [SEL_W-1:0] RST_STAB    = 3'h4;
  localparam logic [1:0]       SRC_CRYSTAL = 2'h0;
  localparam logic [1:0]       SRC_RING    = 2'h1;
  localparam logic [1:0]       SRC_SUB     = 2'h2;

  // ---------------------------------------------------------------
  // peripheral clock from the internal oscillator
  // ---------------------------------------------------------------
  localparam int   RING_KHZ     = 480;
  localparam int   PERIPH_KHZ   = 240;
  localparam int   RING_DIV     = RING_KHZ / PERIPH_KHZ;
  localparam int   DIV_W        = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RING_DIV - 1);

  typedef enum logic [1:0] {RUN, STOPPED, WAIT_OSC, SETTLING} power_state_t;
endpackage

// one sticky stabilization flag: set at its threshold, held until cleared
module stab_flag
  import clock_ctrl_pkg::*;
#(
  parameter logic [CNT_W-1:0] THRESHOLD = 20'h00800
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             clear,
  input  wire logic             allowed,
  input  wire logic [CNT_W-1:0] count,
  output logic                  flag
);
  wire reached = allowed && (count >= THRESHOLD);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (reached) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule

// ---- clock_ctrl.sv ----
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns

// Behaviour
// - ring clock feeds peripherals divided, 240 kHz
// - watchdog, monitor, timer stay usable; timer external input blocked on ring clock
// - on subsystem clock, halt bit stops crystal
// - flags set in order, stay set until stop mode is entered
// - counting ends at programmed stabilization time
// - wait measured from oscillation start only
module clock_ctrl
  import clock_ctrl_pkg::*;
#(
  parameter logic [CNT_W-1:0] T_FLAG0 = 20'h00800,
  parameter logic [CNT_W-1:0] T_FLAG1 = 20'h02000,
  parameter logic [CNT_W-1:0] T_FLAG2 = 20'h04000,
  parameter logic [CNT_W-1:0] T_FLAG3 = 20'h08000,
  parameter logic [CNT_W-1:0] T_FLAG4 = 20'h10000
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        internal_oscillator_tick,
  input  wire logic        crystal_running,
  input  wire logic        stop_enter,
  input  wire logic        stop_release,
  output logic      [1:0]  cpu_clk_src,
  output logic             crystal_osc_enable,
  output logic             periph_clk_tick,
  output logic             cpu_hold,
  output logic             timer_ext_input_allow,
  output logic             ring_safe_periph_enable
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic             main_clock_select_bit;
  logic             main_clock_status_bit;
  logic             subsystem_clock_select;
  logic             crystal_halt_bit;
  logic             main_osc_stop_bit;
  logic [SEL_W-1:0] stabilization_time_select;
  logic [CNT_W-1:0] stab_count;
  logic [DIV_W-1:0] div_count;
  logic [NUM_FLAGS-1:0] stabilization_status_counter;
  power_state_t     state;
  power_state_t     next_state;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire do_write  = write && !waitrequest;
  wire wr_mode   = do_write && (address == ADDR_MAIN_MODE);
  wire wr_proc   = do_write && (address == ADDR_PROC_CLOCK);
  wire wr_osc    = do_write && (address == ADDR_OSC_CTRL);
  wire wr_stab   = do_write && (address == ADDR_STAB_SEL);
  wire req_first = (read || write) && waitrequest;

  logic [31:0] read_mux;
  always_comb begin
    read_mux = 32'h0000_0000;
    case (address)
      ADDR_MAIN_MODE: begin
        read_mux[SEL_BIT]    = main_clock_select_bit;
        read_mux[STATUS_BIT] = main_clock_status_bit;
      end
      ADDR_PROC_CLOCK: begin
        read_mux[SUB_SEL_BIT] = subsystem_clock_select;
        read_mux[HALT_BIT] = crystal_halt_bit;
      end
      ADDR_OSC_CTRL:  read_mux[MAIN_STOP_BIT] = main_osc_stop_bit;
      ADDR_STAB_SEL:  read_mux[SEL_W-1:0] = stabilization_time_select;
      ADDR_STAB_STAT: read_mux[NUM_FLAGS-1:0] = stabilization_status_counter;
      default:        read_mux = 32'h0000_0000;
    endcase
  end

  // one wait cycle per access; data and completion on the following edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= !req_first;
      if (req_first && read) begin
        readdata <= read_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // the status bit follows the select bit only once the crystal is up
  wire crystal_ready = crystal_running && (state == RUN);
  wire next_status   = main_clock_select_bit && crystal_ready;
  // main stop is ignored while cpu uses crystal or the subsystem clock
  wire main_stop_ok  = !main_clock_status_bit && !subsystem_clock_select;
  // subsystem clock may be left only when crystal is selected and running
  wire sub_clear_ok  = main_clock_status_bit && main_clock_select_bit;
  wire next_sub_sel  = writedata[SUB_SEL_BIT] || (subsystem_clock_select && !sub_clear_ok);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      main_clock_select_bit     <= RST_SEL;
      main_clock_status_bit     <= 1'b0;
      subsystem_clock_select    <= 1'b0;
      crystal_halt_bit          <= 1'b0;
      main_osc_stop_bit         <= 1'b0;
      stabilization_time_select <= RST_STAB;
    end else begin
      main_clock_status_bit <= next_status;
      if (wr_mode) begin
        main_clock_select_bit <= writedata[SEL_BIT];
      end
      if (wr_proc) begin
        subsystem_clock_select <= next_sub_sel;
        crystal_halt_bit       <= writedata[HALT_BIT];
      end
      if (wr_osc) begin
        main_osc_stop_bit <= writedata[MAIN_STOP_BIT] && main_stop_ok;
      end
      if (wr_stab) begin
        stabilization_time_select <= writedata[SEL_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // stop mode and stabilization wait
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] sel_time;
  always_comb begin
    case (stabilization_time_select)
      3'h0:    sel_time = T_FLAG0;
      3'h1:    sel_time = T_FLAG1;
      3'h2:    sel_time = T_FLAG2;
      3'h3:    sel_time = T_FLAG3;
      default: sel_time = T_FLAG4;
    endcase
  end

  wire count_done = (stab_count >= sel_time);

  always_comb begin
    next_state = state;
    case (state)
      RUN:      if (stop_enter) next_state = STOPPED;
      STOPPED:  if (stop_release) next_state = WAIT_OSC;
      WAIT_OSC: if (crystal_running) next_state = SETTLING;
      SETTLING: if (count_done) next_state = RUN;
      default:  next_state = RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state      <= WAIT_OSC;
      stab_count <= 20'h00000;
    end else begin
      state <= next_state;
      if (state == STOPPED) begin
        stab_count <= 20'h00000;
      end else if ((state != RUN) && crystal_running && !count_done) begin
        stab_count <= stab_count + 20'h00001;
      end
    end
  end

  // flags only up to the programmed time are reported; in the first stopped
  // cycle the count still holds the last wake-up, so no flag may set from it
  wire flags_clear = (state == STOPPED);
  wire [NUM_FLAGS-1:0] flag_allowed;
  assign flag_allowed[0] = (T_FLAG0 <= sel_time) && !flags_clear;
  assign flag_allowed[1] = (T_FLAG1 <= sel_time) && !flags_clear;
  assign flag_allowed[2] = (T_FLAG2 <= sel_time) && !flags_clear;
  assign flag_allowed[3] = (T_FLAG3 <= sel_time) && !flags_clear;
  assign flag_allowed[4] = (T_FLAG4 <= sel_time) && !flags_clear;

  stab_flag #(.THRESHOLD(T_FLAG0)) u_flag0 (.ref_clk(ref_clk), .rstn(rstn),
    .clear(flags_clear), .allowed(flag_allowed[0]), .count(stab_count),
    .flag(stabilization_status_counter[0]));
  stab_flag #(.THRESHOLD(T_FLAG1)) u_flag1 (.ref_clk(ref_clk), .rstn(rstn),
    .clear(flags_clear), .allowed(flag_allowed[1]), .count(stab_count),
    .flag(stabilization_status_counter[1]));
  stab_flag #(.THRESHOLD(T_FLAG2)) u_flag2 (.ref_clk(ref_clk), .rstn(rstn),
    .clear(flags_clear), .allowed(flag_allowed[2]), .count(stab_count),
    .flag(stabilization_status_counter[2]));
  stab_flag #(.THRESHOLD(T_FLAG3)) u_flag3 (.ref_clk(ref_clk), .rstn(rstn),
    .clear(flags_clear), .allowed(flag_allowed[3]), .count(stab_count),
    .flag(stabilization_status_counter[3]));
  stab_flag #(.THRESHOLD(T_FLAG4)) u_flag4 (.ref_clk(ref_clk), .rstn(rstn),
    .clear(flags_clear), .allowed(flag_allowed[4]), .count(stab_count),
    .flag(stabilization_status_counter[4]));

  // ---------------------------------------------------------------
  // clock source, crystal gate and peripheral clock
  // ---------------------------------------------------------------
  wire [1:0] next_src = subsystem_clock_select ? SRC_SUB :
                        main_clock_status_bit  ? SRC_CRYSTAL : SRC_RING;
  // on the subsystem clock only the halt bit or stop mode may stop the crystal
  wire crystal_stop   = subsystem_clock_select ? crystal_halt_bit
                                               : main_osc_stop_bit;
  wire on_ring        = (next_src == SRC_RING);
  wire div_wrap       = internal_oscillator_tick && (div_count == DIV_LAST);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_clk_src             <= SRC_RING;
      crystal_osc_enable      <= 1'b1;
      periph_clk_tick         <= 1'b0;
      cpu_hold                <= 1'b1;
      timer_ext_input_allow   <= 1'b0;
      ring_safe_periph_enable <= 1'b1;
      div_count               <= 4'h0;
    end else begin
      cpu_clk_src        <= next_src;
      crystal_osc_enable <= !crystal_stop && (state != STOPPED);
      cpu_hold           <= (next_state != RUN);
      if (internal_oscillator_tick) begin
        div_count <= div_wrap ? 4'h0 : div_count + 4'h1;
      end
      periph_clk_tick         <= on_ring && div_wrap;
      timer_ext_input_allow   <= !on_ring;
      ring_safe_periph_enable <= 1'b1;
    end
  end
endmodule

// ---- clock_ctrl_sva.sv ----
`timescale 1ns/1ns
module clock_ctrl_sva
  import clock_ctrl_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        internal_oscillator_tick,
  input wire logic        crystal_running,
  input wire logic        stop_enter,
  input wire logic        stop_release,
  input wire logic [1:0]  cpu_clk_src,
  input wire logic        crystal_osc_enable,
  input wire logic        periph_clk_tick,
  input wire logic        cpu_hold,
  input wire logic        timer_ext_input_allow,
  input wire logic        ring_safe_periph_enable
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_BUS_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered after one wait cycle");
  AST_ONE_WAIT: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_TICK_RING: assert property (periph_clk_tick |-> cpu_clk_src == SRC_RING)
    else $error("peripheral tick while not on internal oscillator");
  AST_TICK_SPACING: assert property (periph_clk_tick |=> !periph_clk_tick)
    else $error("peripheral tick not divided");
  AST_EXT_BLOCK: assert property ((cpu_clk_src == SRC_RING)[*2] |-> !timer_ext_input_allow)
    else $error("timer external input allowed on internal oscillator");
  AST_SAFE_ON: assert property (ring_safe_periph_enable)
    else $error("safe peripherals disabled");
  AST_HOLD_OSC: assert property (cpu_hold && !crystal_running |=> cpu_hold)
    else $error("hold released before oscillation started");
  AST_STOP_HOLD: assert property (stop_enter && !cpu_hold |-> ##[1:2] cpu_hold)
    else $error("stop did not hold the cpu");
  COV_WRITE: cover property (write && !waitrequest);
  COV_TICK: cover property (periph_clk_tick);
  COV_SETTLED: cover property ($fell(cpu_hold));
endmodule

bind clock_ctrl clock_ctrl_sva clock_ctrl_sva_inst (
  .ref_clk, .rstn, .address, .read, .write, .writedata, .readdata, .waitrequest,
  .internal_oscillator_tick, .crystal_running, .stop_enter, .stop_release, .cpu_clk_src,
  .crystal_osc_enable, .periph_clk_tick, .cpu_hold, .timer_ext_input_allow,
  .ring_safe_periph_enable
);

// ---- clock_ctrl_tb.sv ----
`timescale 1ns/1ns
module clock_ctrl_tb;
  import clock_ctrl_pkg::*;
  logic        ref_clk, rstn, read, write, internal_oscillator_tick, crystal_running, stop_enter;
  logic        stop_release, waitrequest, crystal_osc_enable, periph_clk_tick, cpu_hold;
  logic        timer_ext_input_allow, ring_safe_periph_enable;
  logic [4:0]  address;
  logic [1:0]  cpu_clk_src;
  logic [31:0] writedata, readdata, q;
  int          bad_count, total_checks, n;

  clock_ctrl #(.T_FLAG0(20'h4), .T_FLAG1(20'h8), .T_FLAG2(20'hC), .T_FLAG3(20'h10),
    .T_FLAG4(20'h14)) clock_ctrl_inst (
    .ref_clk, .rstn, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .internal_oscillator_tick, .crystal_running, .stop_enter, .stop_release, .cpu_clk_src,
    .crystal_osc_enable, .periph_clk_tick, .cpu_hold, .timer_ext_input_allow,
    .ring_safe_periph_enable
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task timeout(input string what);
    bad_count++;
    $display("[FAIL] %s expected completion seen timeout", what);
    end_of_test();
  endtask

  task bus(input logic we, input logic [4:0] a, input logic [31:0] d);
    int k;
    address <= a;
    writedata <= d;
    read <= !we;
    write <= we;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    if (waitrequest !== 1'b0) timeout("bus");
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task wr_rd(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    bus(1'b0, a, 32'h0);
  endtask

  task wait_hold;
    n = 0;
    while (cpu_hold !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (cpu_hold !== 1'b0) timeout("hold");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_settle;
    repeat (10) @(posedge ref_clk);
    check("hold before oscillation", cpu_hold, 1'b1);
    crystal_running <= 1'b1;
    wait_hold();
    check("settle time", n >= 20, 1'b1);
    check("safe periph", ring_safe_periph_enable, 1'b1);
    $display("test settle done");
  endtask

  task t_ring;
    int k;
    k = 0;
    for (int i = 0; i < 28; i++) begin
      internal_oscillator_tick <= (i % 3 == 0) && (i < 24);
      @(posedge ref_clk);
      if (periph_clk_tick === 1'b1) k++;
    end
    check("periph ticks", k, 32'h4);
    check("ext input", timer_ext_input_allow, 1'b0);
    $display("test ring done");
  endtask

  task t_stop;
    bus(1'b1, ADDR_STAB_SEL, 32'h2);
    stop_enter <= 1'b1;
    @(posedge ref_clk);
    stop_enter <= 1'b0;
    crystal_running <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("crystal off", crystal_osc_enable, 1'b0);
    stop_release <= 1'b1;
    @(posedge ref_clk);
    stop_release <= 1'b0;
    repeat (30) @(posedge ref_clk);
    check("hold waiting", cpu_hold, 1'b1);
    crystal_running <= 1'b1;
    wait_hold();
    check("stop settle", n >= 12, 1'b1);
    bus(1'b0, ADDR_STAB_STAT, 32'h0);
    check("flags", q, 32'h7);
    $display("test stop done");
  endtask

  task t_short;
    bus(1'b1, ADDR_STAB_SEL, 32'h0);
    stop_enter <= 1'b1;
    @(posedge ref_clk);
    stop_enter <= 1'b0;
    stop_release <= 1'b1;
    crystal_running <= 1'b0;
    @(posedge ref_clk);
    stop_release <= 1'b0;
    bus(1'b0, ADDR_STAB_STAT, 32'h0);
    check("flags before oscillation", q, 32'h0);
    crystal_running <= 1'b1;
    wait_hold();
    check("short settle", n >= 4, 1'b1);
    bus(1'b0, ADDR_STAB_STAT, 32'h0);
    check("short flags", q, 32'h1);
    $display("test short done");
  endtask

  task t_bus;
    wr_rd(ADDR_MAIN_MODE, 32'h1);
    check("mode", q, 32'h3);
    check("src crystal", cpu_clk_src, SRC_CRYSTAL);
    check("ext input crystal", timer_ext_input_allow, 1'b1);
    for (int i = 0; i < 6; i++) begin
      internal_oscillator_tick <= (i < 4);
      @(posedge ref_clk);
      check("no tick on crystal", periph_clk_tick, 1'b0);
    end
    wr_rd(ADDR_OSC_CTRL, 32'h1);
    check("stop refused", q, 32'h0);
    wr_rd(ADDR_PROC_CLOCK, 32'h10);
    check("src sub", cpu_clk_src, SRC_SUB);
    wr_rd(ADDR_OSC_CTRL, 32'h1);
    check("stop on sub", q, 32'h0);
    wr_rd(ADDR_MAIN_MODE, 32'h0);
    wr_rd(ADDR_PROC_CLOCK, 32'h0);
    check("sub clear refused", q, 32'h10);
    wr_rd(ADDR_MAIN_MODE, 32'h1);
    wr_rd(ADDR_PROC_CLOCK, 32'h0);
    check("sub clear taken", q, 32'h0);
    wr_rd(ADDR_PROC_CLOCK, 32'h90);
    check("halt crystal", crystal_osc_enable, 1'b0);
    wr_rd(ADDR_STAB_SEL, 32'hB);
    check("select field", q, 32'h3);
    bus(1'b0, 5'h14, 32'h0);
    check("unmapped", q, 32'h0);
    $display("test bus done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    {rstn, read, write, internal_oscillator_tick, crystal_running, stop_enter, stop_release} = '0;
    address = 5'h00;
    writedata = 32'h0;
    repeat (5) @(posedge ref_clk);
    check("reset src", cpu_clk_src, SRC_RING);
    check("reset ext", timer_ext_input_allow, 1'b0);
    rstn <= 1'b1;
    t_settle();
    t_ring();
    t_stop();
    t_short();
    t_bus();
    end_of_test();
  end
endmodule
